// [pkg/epcg_defs.vh]
// Purpose: constants for the ethernet packet client and generator
// Assumes: word-indexed register access as printed
// Notes: definitions only
`ifndef EPCG_DEFS_VH
`define EPCG_DEFS_VH
// ------------------------------------------------------------
// register indices
// ------------------------------------------------------------
`define EPCG_A_MII_START    16'h0000
`define EPCG_A_MII_PASS     16'h0002
`define EPCG_A_SCRATCH      16'h1000
`define EPCG_A_IDENT        16'h1001
`define EPCG_A_SIZE_CFG     16'h1008
`define EPCG_A_FRAME_CNT    16'h1009
`define EPCG_A_TX_CTRL      16'h1010
`define EPCG_A_DST_LO       16'h1011
`define EPCG_A_DST_HI       16'h1012
`define EPCG_A_SRC_LO       16'h1013
`define EPCG_A_SRC_HI       16'h1014
`define EPCG_A_LB_RESET     16'h1016
// ------------------------------------------------------------
// reset values and fields
// ------------------------------------------------------------
`define EPCG_SIZE_RST       32'h25800040
`define EPCG_COUNT_RST      32'h0000000a
`define EPCG_CTRL_RST       8'h06
`define EPCG_CTRL_DIS_BIT   1
`define EPCG_CTRL_LB_BIT    3
`define EPCG_SIZE_LIM_HI    29
`define EPCG_SIZE_LIM_LO    16
`define EPCG_SIZE_VAL_HI    13
`define EPCG_SIZE_VAL_LO    0
`define EPCG_MIN_FRAME      14'h0040
// ------------------------------------------------------------
// alignment marker timing, in words per virtual lane
// ------------------------------------------------------------
`define EPCG_AM_SIM_WORDS   16'h0200
`define EPCG_AM_STD_WORDS   16'h4000
// fifo shape
`define EPCG_FIFO_W         8
`define EPCG_FIFO_D         8
`define EPCG_FIFO_AW        3
`endif

// [rtl/epcg_fifo.v]
// Purpose: small flip-flop fifo in the transmit byte path
// Assumes: single clock, synchronous active-low reset
// Notes: full and empty are exact; count is one bit wider than index
`timescale 1ns/1ps
`default_nettype none
module epcg_fifo #(
    parameter W = 8,
    parameter D = 8,
    parameter AW = 3
) (
    input wire sys_clk,
    input wire rstn,
    input wire ce,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_q [0:D-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;
    // handshakes are combinational from the count
    assign in_ready = (cnt_q != D[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem_q[rp_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    // ------------------------------------------------------------
    // pointers and storage
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!rstn) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (push) begin
                mem_q[wp_q] <= in_data;
                wp_q <= wp_q + 1'b1;
            end
            if (pop)
                rp_q <= rp_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule // epcg_fifo
`default_nettype wire

// [rtl/epcg_mii_gen.v]
// Purpose: simple mii pattern generator and loop checker
// Assumes: received bytes return in order on the same clock domain
// Notes: pass drops on a mismatch and stays low until a new start
`timescale 1ns/1ps
`default_nettype none
module epcg_mii_gen (
    input wire sys_clk,
    input wire rstn,
    input wire ce,
    input wire start,
    output reg [7:0] mii_tx_data,
    output reg mii_tx_valid,
    input wire [7:0] mii_rx_data,
    input wire mii_rx_valid,
    output reg pass
);
    reg [7:0] exp_q;
    reg start_q;
    // ------------------------------------------------------------
    // incrementing byte pattern, checked on return
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!rstn) begin
            mii_tx_data <= 8'h00;
            mii_tx_valid <= 1'b0;
            exp_q <= 8'h00;
            start_q <= 1'b0;
            pass <= 1'b0;
        end else if (ce) begin
            start_q <= start;
            mii_tx_valid <= start;
            if (start && !start_q) begin
                // new run: clear pattern and presume pass
                mii_tx_data <= 8'h00;
                exp_q <= 8'h00;
                pass <= 1'b1;
            end else begin
                if (start)
                    mii_tx_data <= mii_tx_data + 8'h01;
                if (mii_rx_valid) begin
                    exp_q <= mii_rx_data + 8'h01;
                    if (mii_rx_data != exp_q)
                        pass <= 1'b0;
                end
            end
        end
    end
endmodule // epcg_mii_gen
`default_nettype wire

// [rtl/epcg_top.v]
// Purpose: packet client and generator with register file
// Assumes: word-indexed register port, clients of one clock
// Notes: frames are emitted as bytes through an 8-word fifo
`timescale 1ns/1ps
`default_nettype none
`include "epcg_defs.vh"
module epcg_top #(
    parameter [31:0] IDENT_WORD = 32'h41424344 // arbitrary value
) (
    input wire sys_clk,
    input wire rstn,
    input wire ce,
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    output reg reg_rvalid,
    input wire incr_mode,
    input wire loopback_mode,
    input wire rx_aligned,
    input wire async_clk_en,
    input wire divided_core_clock_out,
    input wire core_clk,
    output wire tx_client_clk,
    output wire rx_client_clk,
    output wire [7:0] tx_data,
    output wire tx_valid,
    input wire tx_ready,
    output reg tx_sof,
    output reg tx_eof_seen,
    output reg loopback_rst,
    output wire [7:0] mii_tx_data,
    output wire mii_tx_valid,
    input wire [7:0] mii_rx_data,
    input wire mii_rx_valid,
    output wire [15:0] am_interval,
    output reg gen_busy
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    localparam S_IDLE = 2'd0;
    localparam S_HDR = 2'd1;
    localparam S_BODY = 2'd2;
    localparam S_DONE = 2'd3;
    // picks byte n of the 48-bit address, most significant first
    function [7:0] mac_byte;
        input [47:0] mac;
        input [2:0] n;
        begin
            case (n)
                3'd0: mac_byte = mac[47:40];
                3'd1: mac_byte = mac[39:32];
                3'd2: mac_byte = mac[31:24];
                3'd3: mac_byte = mac[23:16];
                3'd4: mac_byte = mac[15:8];
                default: mac_byte = mac[7:0];
            endcase
        end
    endfunction
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [31:0] scratch_q;
    reg [31:0] size_q;
    reg [31:0] count_q;
    reg [7:0] ctrl_q;
    reg [31:0] dst_lo_q;
    reg [15:0] dst_hi_q;
    reg [31:0] src_lo_q;
    reg [15:0] src_hi_q;
    reg mii_start_q;
    reg aln_s1_q;
    reg aln_s2_q;
    reg lbm_s1_q;
    reg lbm_s2_q;
    reg [1:0] st_q;
    reg [31:0] sent_q;
    reg [13:0] len_q;
    reg [13:0] pos_q;
    reg [7:0] byte_d;
    wire fifo_in_ready;
    wire mii_pass;
    wire [47:0] dst_mac;
    wire [47:0] src_mac;
    wire [13:0] lim;
    wire [13:0] step;
    wire [14:0] next_len;
    wire disabled;
    wire emit;
    assign dst_mac = {dst_hi_q, dst_lo_q};
    assign src_mac = {src_hi_q, src_lo_q};
    assign lim = size_q[`EPCG_SIZE_LIM_HI:`EPCG_SIZE_LIM_LO];
    assign step = size_q[`EPCG_SIZE_VAL_HI:`EPCG_SIZE_VAL_LO];
    assign next_len = {1'b0, len_q} + {1'b0, step};
    assign disabled = ctrl_q[`EPCG_CTRL_DIS_BIT];
    // only move a byte when the fifo can take it
    assign emit = (st_q == S_HDR || st_q == S_BODY) && fifo_in_ready;
    // the core clock choice is a plain mux; glitch-free switching is
    // left to the clocking layer around this block
    assign tx_client_clk = async_clk_en ? divided_core_clock_out
                                        : core_clk;
    assign rx_client_clk = async_clk_en ? divided_core_clock_out
                                        : core_clk;
    // markers every 512 words in the shortened model
    assign am_interval = `EPCG_AM_SIM_WORDS;
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!rstn) begin
            aln_s1_q <= 1'b0;
            aln_s2_q <= 1'b0;
            lbm_s1_q <= 1'b0;
            lbm_s2_q <= 1'b0;
        end else if (ce) begin
            aln_s1_q <= rx_aligned;
            aln_s2_q <= aln_s1_q;
            lbm_s1_q <= loopback_mode;
            lbm_s2_q <= lbm_s1_q;
        end
    end
    // ------------------------------------------------------------
    // register writes and reads
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!rstn) begin
            scratch_q <= 32'h00000000;
            size_q <= `EPCG_SIZE_RST;
            count_q <= `EPCG_COUNT_RST;
            ctrl_q <= `EPCG_CTRL_RST;
            dst_lo_q <= 32'h00000000;
            dst_hi_q <= 16'h0000;
            src_lo_q <= 32'h00000000;
            src_hi_q <= 16'h0000;
            mii_start_q <= 1'b0;
            loopback_rst <= 1'b0;
            reg_rdata <= 32'h00000000;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            // loopback reset is a one-cycle pulse per write of one
            loopback_rst <= reg_wr && reg_addr == `EPCG_A_LB_RESET &&
                            reg_wdata[0];
            reg_rvalid <= reg_rd;
            if (reg_wr) begin
                case (reg_addr)
                    `EPCG_A_SCRATCH: scratch_q <= reg_wdata;
                    `EPCG_A_SIZE_CFG: size_q <= {2'b00, reg_wdata[29:0]};
                    `EPCG_A_FRAME_CNT: count_q <= reg_wdata;
                    // reserved bits 0 and 2 keep reset value; bit 3
                    // is status and not stored
                    `EPCG_A_TX_CTRL: ctrl_q <= {ctrl_q[7:4], 1'b0,
                        ctrl_q[2], reg_wdata[1], ctrl_q[0]};
                    `EPCG_A_DST_LO: dst_lo_q <= reg_wdata;
                    `EPCG_A_DST_HI: dst_hi_q <= reg_wdata[15:0];
                    `EPCG_A_SRC_LO: src_lo_q <= reg_wdata;
                    `EPCG_A_SRC_HI: src_hi_q <= reg_wdata[15:0];
                    `EPCG_A_MII_START: mii_start_q <= reg_wdata[0];
                    default: ; // identity and unmapped writes ignored
                endcase
            end
            if (reg_rd) begin
                case (reg_addr)
                    `EPCG_A_SCRATCH: reg_rdata <= scratch_q;
                    `EPCG_A_IDENT: reg_rdata <= IDENT_WORD;
                    `EPCG_A_SIZE_CFG: reg_rdata <= size_q;
                    `EPCG_A_FRAME_CNT: reg_rdata <= count_q;
                    `EPCG_A_TX_CTRL: reg_rdata <= {24'h000000,
                        ctrl_q[7:4], lbm_s2_q, ctrl_q[2:0]};
                    `EPCG_A_DST_LO: reg_rdata <= dst_lo_q;
                    `EPCG_A_DST_HI: reg_rdata <= {16'h0000, dst_hi_q};
                    `EPCG_A_SRC_LO: reg_rdata <= src_lo_q;
                    `EPCG_A_SRC_HI: reg_rdata <= {16'h0000, src_hi_q};
                    `EPCG_A_MII_START: reg_rdata <= {31'h0, mii_start_q};
                    `EPCG_A_MII_PASS: reg_rdata <= {30'h0, mii_pass,
                        1'b0};
                    default: reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end
    // ------------------------------------------------------------
    // frame byte selection
    // ------------------------------------------------------------
    // header is dst then src; body is a running low byte of position
    always @* begin
        byte_d = pos_q[7:0];
        if (st_q == S_HDR) begin
            if (pos_q < 14'd6)
                byte_d = mac_byte(dst_mac, pos_q[2:0]);
            else
                byte_d = mac_byte(src_mac, pos_q[2:0] - 3'd6);
        end
    end
    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    // waits for alignment and a clear disable bit, then emits count frames
    always @(posedge sys_clk) begin
        if (!rstn) begin
            st_q <= S_IDLE;
            sent_q <= 32'h00000000;
            len_q <= 14'h0000;
            pos_q <= 14'h0000;
            tx_sof <= 1'b0;
            tx_eof_seen <= 1'b0;
            gen_busy <= 1'b0;
        end else if (ce) begin
            tx_sof <= 1'b0;
            tx_eof_seen <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    sent_q <= 32'h00000000;
                    // first length: fixed value or the smallest size
                    len_q <= incr_mode ? `EPCG_MIN_FRAME : step;
                    if (!disabled && aln_s2_q &&
                        count_q != 32'h0) begin
                        st_q <= S_HDR;
                        pos_q <= 14'h0000;
                        tx_sof <= 1'b1;
                        gen_busy <= 1'b1;
                    end
                end
                S_HDR, S_BODY: if (emit) begin
                    pos_q <= pos_q + 14'd1;
                    if (pos_q == 14'd11)
                        st_q <= S_BODY;
                    // frames no longer than the header end with its last
                    // byte, so a short length never adds a body byte
                    if (pos_q >= 14'd11 && pos_q + 14'd1 >= len_q) begin
                        tx_eof_seen <= 1'b1;
                        sent_q <= sent_q + 32'h1;
                        pos_q <= 14'h0000;
                        if (incr_mode) begin
                            // grow until the limit, then wrap
                            if (next_len > {1'b0, lim})
                                len_q <= `EPCG_MIN_FRAME;
                            else
                                len_q <= next_len[13:0];
                        end else
                            len_q <= step;
                        if (sent_q + 32'h1 >= count_q || disabled)
                            st_q <= S_DONE;
                        else begin
                            st_q <= S_HDR;
                            tx_sof <= 1'b1;
                        end
                    end
                end
                S_DONE: begin
                    gen_busy <= 1'b0;
                    // re-arm only after software toggles disable
                    if (disabled)
                        st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // transmit fifo and mii generator
    // ------------------------------------------------------------
    epcg_fifo #(
        .W(`EPCG_FIFO_W),
        .D(`EPCG_FIFO_D),
        .AW(`EPCG_FIFO_AW)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .in_valid(emit),
        .in_ready(fifo_in_ready),
        .in_data(byte_d),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );
    epcg_mii_gen u_mii (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .start(mii_start_q),
        .mii_tx_data(mii_tx_data),
        .mii_tx_valid(mii_tx_valid),
        .mii_rx_data(mii_rx_data),
        .mii_rx_valid(mii_rx_valid),
        .pass(mii_pass)
    );
endmodule // epcg_top
`default_nettype wire

// [bench/epcg_props.sv]
// Purpose: port-level checker for the packet client and generator
// Assumes: single clock, synchronous active-low reset
// Notes: the disable bit is mirrored from register writes
`timescale 1ns/1ps
`default_nettype none
module epcg_props #(
    parameter [31:0] IDENT_WORD = 32'h0
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic async_clk_en,
    input wire logic divided_core_clock_out,
    input wire logic core_clk,
    input wire logic tx_client_clk,
    input wire logic rx_client_clk,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_sof,
    input wire logic loopback_rst,
    input wire logic [15:0] am_interval
);
    // ------
    // helper: shadow of the generator disable bit, set after reset
    // ------
    logic dis_q;
    always @(posedge sys_clk) begin
        if (!rstn)
            dis_q <= 1'b1;
        else if (ce && reg_wr && reg_addr == 16'h1010)
            dis_q <= reg_wdata[1];
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_rvalid;
        reg_rvalid |-> $past(reg_rd && ce);
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("stray read valid");
    property p_ident;
        ce && reg_rd && reg_addr == 16'h1001 |=> reg_rdata == IDENT_WORD;
    endproperty
    a_ident: assert property (p_ident) else $error("ident word wrong");
    property p_unmapped;
        ce && reg_rd && reg_addr == 16'h1005 |=> reg_rvalid && reg_rdata == 0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_am;
        am_interval == 16'h0200;
    endproperty
    a_am: assert property (p_am) else $error("marker interval wrong");
    property p_mux;
        tx_client_clk == (async_clk_en ? divided_core_clock_out : core_clk)
            && rx_client_clk == tx_client_clk;
    endproperty
    a_mux: assert property (p_mux) else $error("client clock select");
    property p_stall;
        ce && tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_stall: assert property (p_stall) else $error("stream moved in stall");
    property p_dis;
        tx_sof |-> !$past(dis_q);
    endproperty
    a_dis: assert property (p_dis) else $error("frame while disabled");
    property p_sof;
        tx_sof |-> ##[1:3] tx_valid;
    endproperty
    a_sof: assert property (p_sof) else $error("frame start without data");
    property p_lb;
        ce && reg_wr && reg_addr == 16'h1016 && reg_wdata[0]
            |=> loopback_rst ##1 !loopback_rst;
    endproperty
    a_lb: assert property (p_lb) else $error("loopback reset pulse");
endmodule // epcg_props
bind epcg_top epcg_props #(.IDENT_WORD(IDENT_WORD)) epcg_props_inst (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .async_clk_en(async_clk_en),
    .divided_core_clock_out(divided_core_clock_out), .core_clk(core_clk),
    .tx_client_clk(tx_client_clk), .rx_client_clk(rx_client_clk),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_sof(tx_sof), .loopback_rst(loopback_rst), .am_interval(am_interval));
`default_nettype wire

// [bench/epcg_partner.sv]
// Purpose: behavioural model of the mac core client side
// Assumes: driven shortly after the rising edge
// Notes: idle mii data lines invert their previous value every cycle
`timescale 1ns/1ps
`default_nettype none
module epcg_partner (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic stall_en,
    input wire logic corrupt,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic rx_aligned,
    input wire logic [7:0] mii_tx_data,
    input wire logic mii_tx_valid,
    output logic [7:0] mii_rx_data,
    output logic mii_rx_valid
);
    // ------
    // byte sink, alignment and mii loop
    // ------
    logic [7:0] rx_q[$];
    int up_n = 0;
    initial begin
        tx_ready = 1'b1;
        rx_aligned = 1'b0;
        mii_rx_data = 8'h00;
        mii_rx_valid = 1'b0;
    end
    always @(posedge sys_clk) begin
        // keep every accepted byte for the bench to count and compare
        if (tx_valid === 1'b1 && tx_ready)
            rx_q.push_back(tx_data);
        up_n = rstn ? up_n + 1 : 0;
        #1;
        // alignment comes only some time after reset is let go
        rx_aligned <= (up_n > 20);
        // random back-pressure when asked, so the fifo really fills
        tx_ready <= stall_en ? 1'($urandom) : 1'b1;
        // return the same series; corrupt flips a bit on purpose
        mii_rx_valid <= mii_tx_valid;
        mii_rx_data <= mii_tx_valid ? mii_tx_data ^ {7'h0, corrupt} : ~mii_rx_data;
    end
endmodule // epcg_partner
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: self-checking bench for the packet client and generator
// Assumes: ce tied high, 20 MHz sys_clk plus two client clock sources
// Notes: expected byte streams are rebuilt from the register values
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam [31:0] ID_W = 32'h5a5a0001; // arbitrary value
    logic sys_clk = 0, rstn = 0, ce = 1, reg_wr = 0, reg_rd = 0;
    logic [15:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic reg_rvalid, incr_mode = 0, loopback_mode = 0, async_clk_en = 0;
    logic divided_core_clock_out = 0, core_clk = 0, rx_aligned, tx_ready;
    logic tx_client_clk, rx_client_clk, tx_valid, tx_sof, loopback_rst;
    logic [7:0] tx_data, mii_tx_data, mii_rx_data, exp_q[$];
    logic mii_tx_valid, mii_rx_valid, stall_en = 0, corrupt = 0;
    logic [15:0] am_interval;
    logic tx_eof_seen, gen_busy;
    int num_errors = 0, tests_run = 0, sof_n = 0, cyc = 0, eof_n = 0;
    epcg_top #(.IDENT_WORD(ID_W)) epcg_top_inst (.sys_clk(sys_clk),
        .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .incr_mode(incr_mode),
        .loopback_mode(loopback_mode), .rx_aligned(rx_aligned),
        .async_clk_en(async_clk_en),
        .divided_core_clock_out(divided_core_clock_out), .core_clk(core_clk),
        .tx_client_clk(tx_client_clk), .rx_client_clk(rx_client_clk),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_sof(tx_sof), .tx_eof_seen(tx_eof_seen),
        .loopback_rst(loopback_rst),
        .mii_tx_data(mii_tx_data), .mii_tx_valid(mii_tx_valid),
        .mii_rx_data(mii_rx_data), .mii_rx_valid(mii_rx_valid),
        .am_interval(am_interval), .gen_busy(gen_busy));
    epcg_partner epcg_partner_inst (.sys_clk(sys_clk), .rstn(rstn),
        .stall_en(stall_en), .corrupt(corrupt), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_aligned(rx_aligned),
        .mii_tx_data(mii_tx_data), .mii_tx_valid(mii_tx_valid),
        .mii_rx_data(mii_rx_data), .mii_rx_valid(mii_rx_valid));
    // ------
    // clocks, frame-start count and hang guard
    // ------
    initial forever #25 sys_clk = ~sys_clk; // also the csr clock
    initial forever #7 core_clk = ~core_clk;
    initial forever #11 divided_core_clock_out = ~divided_core_clock_out;
    always @(posedge sys_clk) begin
        cyc++;
        if (tx_sof === 1'b1)
            sof_n++;
        if (tx_eof_seen === 1'b1)
            eof_n++;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    // ------
    // helper tasks
    // ------
    task automatic print_verdict();
        if (num_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(posedge sys_clk) #1;
        reg_wr = 0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge sys_clk) #1;
        reg_addr = a;
        reg_rd = 1;
        @(posedge sys_clk) #1;
        reg_rd = 0;
        d = reg_rdata;
        check("rvalid", reg_rvalid, 1);
    endtask
    task automatic rd_chk(input string nm, input logic [15:0] a,
                          input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        check(nm, d, e);
    endtask
    // reference stream: header bytes high first, then low byte of position
    task automatic frames(input int n, input bit inc, input int fix,
                          input logic [47:0] dst, input logic [47:0] src);
        int len;
        len = inc ? 64 : fix;
        for (int f = 0; f < n; f++) begin
            for (int i = 5; i >= 0; i--) exp_q.push_back(dst[8*i +: 8]);
            for (int i = 5; i >= 0; i--) exp_q.push_back(src[8*i +: 8]);
            for (int p = 12; p < len; p++) exp_q.push_back(8'(p));
            if (inc)
                len = (len + 36 > 100) ? 64 : len + 36;
        end
    endtask
    task automatic run_cmp(input int n);
        int k;
        check("idle bytes", epcg_partner_inst.rx_q.size(), 0);
        sof_n = 0;
        eof_n = 0;
        wr(16'h1010, 32'h0);
        for (k = 0; k < 6000; k++) begin
            if (epcg_partner_inst.rx_q.size() >= exp_q.size())
                break;
            @(posedge sys_clk);
        end
        repeat (40) @(posedge sys_clk);
        check("frames", sof_n, n);
        check("frame ends", eof_n, n);
        check("busy", gen_busy, 0);
        check("bytes", epcg_partner_inst.rx_q.size(), exp_q.size());
        foreach (exp_q[i])
            check("byte", epcg_partner_inst.rx_q[i], exp_q[i]);
        wr(16'h1010, 32'hb);
        exp_q.delete();
        epcg_partner_inst.rx_q.delete();
    endtask
    // ------
    // main sequence
    // ------
    initial begin
        logic [31:0] d, sc;
        logic [47:0] dst, src;
        int fl, n;
        void'($urandom(44));
        repeat (2) @(posedge sys_clk);
        #1 rstn = 1;
        rd_chk("size", 16'h1008, 32'h25800040);
        rd_chk("count", 16'h1009, 32'ha);
        rd_chk("ctrl", 16'h1010, 32'h6);
        sc = $urandom;
        wr(16'h1000, sc);
        wr(16'h1001, ~sc);
        wr(16'h1005, sc);
        rd_chk("scratch", 16'h1000, sc);
        rd_chk("ident", 16'h1001, ID_W);
        rd_chk("unmapped", 16'h1005, 32'h0);
        wr(16'h1008, 32'hffffffff);
        rd_chk("size wr", 16'h1008, 32'h3fffffff);
        dst = {$urandom, $urandom};
        src = {$urandom, $urandom};
        wr(16'h1011, dst[31:0]);
        wr(16'h1012, {16'h0, dst[47:32]});
        wr(16'h1013, src[31:0]);
        wr(16'h1014, {16'h0, src[47:32]});
        stall_en = 1;
        // fixed shortest, fixed random, then incremental hitting the limit
        for (int r = 0; r < 3; r++) begin
            fl = (r == 0) ? 12 : 13 + $urandom % 30;
            n = (r == 2) ? 4 : 2 * r + 1;
            incr_mode = (r == 2);
            async_clk_en = r[0];
            wr(16'h1008, (r == 2) ? 32'h00640024 : fl);
            wr(16'h1009, n);
            frames(n, r == 2, fl, dst, src);
            run_cmp(n);
        end
        loopback_mode = 1;
        repeat (4) @(posedge sys_clk);
        rd_chk("ctrl lb", 16'h1010, 32'he);
        wr(16'h1016, 32'h1);
        check("lb pulse", loopback_rst, 1);
        rd_chk("lb reg", 16'h1016, 32'h0);
        wr(16'h0000, 32'h1);
        rd_chk("mii start", 16'h0000, 32'h1);
        repeat (60) @(posedge sys_clk);
        rd(16'h0002, d);
        check("mii pass", d & 32'h2, 32'h2);
        #1 corrupt = 1;
        repeat (5) @(posedge sys_clk);
        #1 corrupt = 0;
        rd(16'h0002, d);
        check("mii fail", d & 32'h2, 32'h0);
        wr(16'h0000, 32'h0);
        repeat (5) @(posedge sys_clk);
        check("mii stop", {31'h0, mii_tx_valid}, 32'h0);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
